// >>> mrc_pkg.sv
package mrc_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_CMD  = 8'h04;
  localparam logic [7:0] OFS_STAT = 8'h08;

  // CTRL fields
  localparam int CTRL_QUIET_BIT   = 0;
  localparam int CTRL_VERBOSE_BIT = 1;
  localparam int CTRL_XSET_LSB    = 2;
  localparam int CTRL_GAP_BIT     = 5;

  // CMD fields
  localparam int CMD_OP_LSB  = 0;
  localparam int CMD_IDX_LSB = 8;
  localparam int CMD_VAL_LSB = 16;

  // STAT fields
  localparam int STAT_CODE_LSB = 8;
  localparam int STAT_BUSY_BIT = 12;
  localparam int STAT_ERR_BIT  = 13;
  localparam int STAT_HUNG_BIT = 14;

  localparam logic [1:0] OP_PEEK = 2'h1;
  localparam logic [1:0] OP_POKE = 2'h2;

  // ****************************************
  // Reset values and limits
  // ****************************************
  localparam logic       RST_QUIET   = 1'h0;
  localparam logic       RST_VERBOSE = 1'h1;
  localparam logic [2:0] RST_XSET    = 3'h4;
  localparam logic       RST_GAP_EN  = 1'h0;
  localparam logic [2:0] XSET_MAX    = 3'h4;
  localparam int         NUM_REGS    = 28;
  localparam logic [7:0] IDX_MAX     = 8'h1B;
  localparam logic [8:0] VAL_MAX     = 9'h0FF;

  // ****************************************
  // Result codes
  // ****************************************
  localparam logic [3:0] RC_OK      = 4'h0;
  localparam logic [3:0] RC_CONNECT = 4'h1;
  localparam logic [3:0] RC_NOCARR  = 4'h3;
  localparam logic [3:0] RC_ERROR   = 4'h4;
  localparam logic [3:0] RC_NOTONE  = 4'h6;
  localparam logic [3:0] RC_BUSY    = 4'h7;
  localparam logic [3:0] RC_CONFAST = 4'hA;

  // ****************************************
  // Timing
  // ****************************************
  localparam int  CLK_HZ       = 10_000_000;
  localparam real LONG_GAP_S   = 1.6;
  localparam int  LONG_GAP_CYC = int'($ceil(LONG_GAP_S * CLK_HZ));

  // ****************************************
  // Types
  // ****************************************
  typedef struct packed {
    logic       gap_en;
    logic [2:0] xset;
    logic       verbose;
    logic       quiet;
  } mrc_ctrl_t;

  typedef struct packed {
    logic full_msgs;
    logic wait_tone;
    logic tone_timeout;
    logic busy_detect;
  } mrc_policy_t;

  typedef struct packed {
    logic       write;
    logic [7:0] addr;
  } mrc_aphase_t;

  // Dialing and reporting policy per result set
  function automatic mrc_policy_t mrc_policy(input logic [2:0] xset);
    mrc_policy_t p;
    p = '0;
    case (xset)
      3'h0: p = '{1'b0, 1'b0, 1'b0, 1'b0};
      3'h1: p = '{1'b1, 1'b0, 1'b0, 1'b0};
      3'h2: p = '{1'b1, 1'b1, 1'b1, 1'b0};
      3'h3: p = '{1'b1, 1'b0, 1'b0, 1'b1};
      default: p = '{1'b1, 1'b1, 1'b1, 1'b1};
    endcase
    return p;
  endfunction : mrc_policy

endpackage : mrc_pkg

// >>> mrc_gap_detect.sv
`timescale 1ns/1ps

module mrc_gap_detect #(
  parameter int GAP_CYC = 16_000_000
) (
  // Clock and reset
  input  wire logic clk_sys_in,
  input  wire logic rst_in,
  // Control and line state
  input  wire logic enable_in,
  input  wire logic online_in,
  input  wire logic space_in,
  // Disconnect request
  output logic      hangup_out
);

  logic [31:0] cnt_q;
  logic        fired_q;

  // ****************************************
  // Continuous space timer
  // ****************************************
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      cnt_q <= 32'h0;
    end else if (!(enable_in && online_in && space_in)) begin
      cnt_q <= 32'h0;
    end else if (cnt_q < 32'(GAP_CYC)) begin
      cnt_q <= cnt_q + 32'h1;
    end
  end

  // One pulse per gap
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      fired_q    <= 1'b0;
      hangup_out <= 1'b0;
    end else begin
      hangup_out <= 1'b0;
      if (cnt_q == 32'h0) begin
        fired_q <= 1'b0;
      end else if (cnt_q == 32'(GAP_CYC) && !fired_q) begin
        fired_q    <= 1'b1;
        hangup_out <= 1'b1;
      end
    end
  end

endmodule : mrc_gap_detect

// >>> mrc_result_cmds.sv
// Added by the designer: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/1ps

module mrc_result_cmds
  import mrc_pkg::*;
#(
  parameter int GAP_CYC = LONG_GAP_CYC
) (
  // Clock and reset
  input  wire logic        clk_sys_in,
  input  wire logic        rst_in,
  // AHB-Lite slave
  input  wire logic        hsel_in,
  input  wire logic [31:0] haddr_in,
  input  wire logic [1:0]  htrans_in,
  input  wire logic        hwrite_in,
  input  wire logic [2:0]  hsize_in,
  input  wire logic [31:0] hwdata_in,
  input  wire logic        hready_in,
  output logic      [31:0] hrdata_out,
  output logic             hreadyout_out,
  output logic             hresp_out,
  // Result characters to host
  output logic      [7:0]  tx_char_out,
  output logic             tx_valid_out,
  input  wire logic        tx_ready_in,
  // Line events from data pump
  input  wire logic        online_in,
  input  wire logic        rx_space_in,
  input  wire logic        connect_in,
  input  wire logic        fast_link_in,
  input  wire logic        busy_tone_in,
  input  wire logic        no_tone_in,
  // Dialing policy and disconnect
  output logic             full_msgs_out,
  output logic             wait_dial_tone_out,
  output logic             tone_timeout_en_out,
  output logic             busy_detect_en_out,
  output logic             hangup_out
);

  // ****************************************
  // Declarations
  // ****************************************
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_SEND = 2'b10
  } mrc_state_t;

  mrc_ctrl_t   ctrl_q;
  mrc_policy_t pol;
  mrc_aphase_t ap_q;
  logic        ap_vld_q;
  logic [7:0]  regs_q [NUM_REGS];
  logic [7:0]  peek_q;
  logic        err_q;
  logic        hung_q;
  logic [3:0]  last_code_q;
  logic        pend_q;
  logic [3:0]  pend_code_q;
  mrc_state_t  st_q;
  logic [127:0] txt_q;
  logic [127:0] start_txt;
  logic [3:0]  len_q;
  logic [3:0]  pos_q;
  logic [5:0]  sync1_q;
  logic [5:0]  sync2_q;
  logic [5:0]  prev_q;
  logic [5:0]  rise;
  logic        gap_hup;
  logic        wr_now;
  logic        cmd_wr;
  logic        ctrl_wr;
  logic [1:0]  cmd_op;
  logic [7:0]  cmd_idx;
  logic [8:0]  cmd_val;
  logic        cmd_bad;
  logic        ev_vld;
  logic [3:0]  ev_code;
  logic        start;
  logic [3:0]  start_code;

  // ****************************************
  // Result text
  // ****************************************
  function automatic logic [127:0] res_text(input logic [3:0] code, input logic verbose);
    logic [127:0] t;
    t = '0;
    if (verbose) begin
      case (code)
        RC_OK:      t = 128'("OK\r\n");
        RC_CONNECT: t = 128'("CONNECT\r\n");
        RC_NOCARR:  t = 128'("NO CARRIER\r\n");
        RC_ERROR:   t = 128'("ERROR\r\n");
        RC_NOTONE:  t = 128'("NO DIALTONE\r\n");
        RC_BUSY:    t = 128'("BUSY\r\n");
        RC_CONFAST: t = 128'("CONNECT 2400\r\n");
        default:    t = 128'("ERROR\r\n");
      endcase
    end else if (code > 4'h9) begin
      t = {104'h0, 8'h31, 8'(8'h30 + code - 4'hA), 8'h0D};
    end else begin
      t = {112'h0, 8'(8'h30 + code), 8'h0D};
    end
    return t;
  endfunction : res_text

  function automatic logic [3:0] res_len(input logic [127:0] t);
    logic [3:0] n;
    n = 4'h0;
    for (int i = 0; i < 16; i++) begin
      if (t[8*i +: 8] != 8'h00) begin
        n = 4'(i + 1);
      end
    end
    return n;
  endfunction : res_len

  // ****************************************
  // Pin synchronisers
  // ****************************************
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      sync1_q <= 6'h00;
      sync2_q <= 6'h00;
      prev_q  <= 6'h00;
    end else begin
      sync1_q <= {no_tone_in, busy_tone_in, fast_link_in,
                  connect_in, rx_space_in, online_in};
      sync2_q <= sync1_q;
      prev_q  <= sync2_q;
    end
  end

  assign rise = sync2_q & ~prev_q;

  // ****************************************
  // Dialing policy
  // ****************************************
  assign pol                 = mrc_policy(ctrl_q.xset);
  assign full_msgs_out       = pol.full_msgs;
  assign wait_dial_tone_out  = pol.wait_tone;
  assign tone_timeout_en_out = pol.tone_timeout;
  assign busy_detect_en_out  = pol.busy_detect;

  // ****************************************
  // Long space disconnect
  // ****************************************
  mrc_gap_detect #(
    .GAP_CYC    (GAP_CYC)
  ) u_gap (
    .clk_sys_in (clk_sys_in),
    .rst_in     (rst_in),
    .enable_in  (ctrl_q.gap_en),
    .online_in  (sync2_q[0]),
    .space_in   (sync2_q[1]),
    .hangup_out (gap_hup)
  );

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      hangup_out <= 1'b0;
      hung_q     <= 1'b0;
    end else begin
      hangup_out <= gap_hup;
      if (gap_hup) begin
        hung_q <= 1'b1;
      end else if (rise[0]) begin
        hung_q <= 1'b0;
      end
    end
  end

  // ****************************************
  // AHB-Lite slave
  // ****************************************
  assign hreadyout_out = 1'b1;
  assign hresp_out     = 1'b0;

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      ap_vld_q <= 1'b0;
      ap_q     <= '0;
    end else if (hready_in) begin
      ap_vld_q <= hsel_in && htrans_in[1] && hwrite_in;
      ap_q     <= '{hwrite_in, haddr_in[7:0]};
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      hrdata_out <= 32'h0;
    end else if (hready_in && hsel_in && htrans_in[1] && !hwrite_in) begin
      case (haddr_in[7:0])
        OFS_CTRL: hrdata_out <= {26'h0, ctrl_q};
        OFS_STAT: hrdata_out <= {17'h0, hung_q, err_q, (st_q == ST_SEND) || pend_q,
                                 last_code_q, peek_q};
        default:  hrdata_out <= 32'h0;
      endcase
    end
  end

  assign wr_now  = ap_vld_q && ap_q.write;
  assign ctrl_wr = wr_now && (ap_q.addr == OFS_CTRL);
  assign cmd_wr  = wr_now && (ap_q.addr == OFS_CMD);
  assign cmd_op  = hwdata_in[CMD_OP_LSB +: 2];
  assign cmd_idx = hwdata_in[CMD_IDX_LSB +: 8];
  assign cmd_val = hwdata_in[CMD_VAL_LSB +: 9];
  assign cmd_bad = (cmd_idx > IDX_MAX) ||
                   ((cmd_op == OP_POKE) && (cmd_val > VAL_MAX));

  // ****************************************
  // Option settings
  // ****************************************
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      ctrl_q <= '{RST_GAP_EN, RST_XSET, RST_VERBOSE, RST_QUIET};
    end else if (ctrl_wr) begin
      ctrl_q.quiet   <= hwdata_in[CTRL_QUIET_BIT];
      ctrl_q.verbose <= hwdata_in[CTRL_VERBOSE_BIT];
      ctrl_q.gap_en  <= hwdata_in[CTRL_GAP_BIT];
      if (hwdata_in[CTRL_XSET_LSB +: 3] <= XSET_MAX) begin
        ctrl_q.xset <= hwdata_in[CTRL_XSET_LSB +: 3];
      end
    end
  end

  // ****************************************
  // Configuration registers
  // ****************************************
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        regs_q[i] <= 8'h00;
      end
    end else if (cmd_wr && (cmd_op == OP_POKE) && !cmd_bad) begin
      regs_q[5'(cmd_idx)] <= cmd_val[7:0];
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      peek_q <= 8'h00;
      err_q  <= 1'b0;
    end else if (cmd_wr) begin
      err_q <= cmd_bad || !(cmd_op inside {OP_PEEK, OP_POKE});
      if ((cmd_op == OP_PEEK) && !cmd_bad) begin
        peek_q <= regs_q[5'(cmd_idx)];
      end
    end
  end

  // ****************************************
  // Command result pending slot
  // ****************************************
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      pend_q      <= 1'b0;
      pend_code_q <= RC_OK;
    end else if (cmd_wr) begin
      pend_q      <= 1'b1;
      pend_code_q <= (cmd_bad || !(cmd_op inside {OP_PEEK, OP_POKE})) ?
                     RC_ERROR : RC_OK;
    end else if (start || ctrl_q.quiet) begin
      pend_q <= 1'b0;
    end
  end

  // ****************************************
  // Line event results
  // ****************************************
  always_comb begin
    ev_vld  = 1'b0;
    ev_code = RC_OK;
    if (gap_hup) begin
      ev_vld  = 1'b1;
      ev_code = RC_NOCARR;
    end else if (rise[5] && pol.wait_tone) begin
      ev_vld  = 1'b1;
      ev_code = RC_NOTONE;
    end else if (rise[4]) begin
      ev_vld  = 1'b1;
      ev_code = pol.busy_detect ? RC_BUSY : RC_NOCARR;
    end else if (rise[2]) begin
      ev_vld  = 1'b1;
      ev_code = (pol.full_msgs && sync2_q[3]) ? RC_CONFAST : RC_CONNECT;
    end
  end

  always_comb begin
    start      = 1'b0;
    start_code = RC_OK;
    if ((st_q == ST_IDLE) && !ctrl_q.quiet) begin
      if (pend_q) begin
        start      = 1'b1;
        start_code = pend_code_q;
      end else if (ev_vld) begin
        start      = 1'b1;
        start_code = ev_code;
      end
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      last_code_q <= RC_OK;
    end else if (start) begin
      last_code_q <= start_code;
    end else if (ev_vld && (st_q == ST_IDLE)) begin
      last_code_q <= ev_code;
    end
  end

  // ****************************************
  // Result transmitter
  // ****************************************
  assign start_txt = res_text(start_code, ctrl_q.verbose);

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      st_q  <= ST_IDLE;
      txt_q <= 128'h0;
      len_q <= 4'h0;
      pos_q <= 4'h0;
    end else begin
      case (st_q)
        ST_IDLE: begin
          if (start) begin
            txt_q <= start_txt;
            len_q <= res_len(start_txt);
            pos_q <= 4'h0;
            st_q  <= ST_SEND;
          end
        end
        ST_SEND: begin
          if (tx_ready_in) begin
            if (pos_q == len_q - 4'h1) begin
              st_q <= ST_IDLE;
            end
            pos_q <= pos_q + 4'h1;
          end
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      tx_char_out <= 8'h00;
    end else if (start) begin
      tx_char_out <= start_txt[8*(res_len(start_txt) - 4'h1) +: 8];
    end else if ((st_q == ST_SEND) && tx_ready_in && (pos_q != len_q - 4'h1)) begin
      tx_char_out <= txt_q[8*(len_q - pos_q - 4'h2) +: 8];
    end
  end

  assign tx_valid_out = (st_q == ST_SEND);

endmodule : mrc_result_cmds

// >>> mrc_result_cmds_assertions.sv
`timescale 1ns/1ps

module mrc_result_cmds_checker
  import mrc_pkg::*;
#(
  parameter int GAP_CYC = 50
) (
  // Clock and reset
  input wire logic        clk_sys_in,
  input wire logic        rst_in,
  // Bus
  input wire logic        hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0]  htrans_in,
  input wire logic        hwrite_in,
  input wire logic [31:0] hwdata_in,
  input wire logic        hready_in,
  input wire logic        hreadyout_out,
  input wire logic        hresp_out,
  // Result characters
  input wire logic [7:0]  tx_char_out,
  input wire logic        tx_valid_out,
  input wire logic        tx_ready_in,
  // Line and policy
  input wire logic        rx_space_in,
  input wire logic        full_msgs_out,
  input wire logic        wait_dial_tone_out,
  input wire logic        tone_timeout_en_out,
  input wire logic        busy_detect_en_out,
  input wire logic        hangup_out
);
  logic        wr_ap;
  logic        ctrl_q, cmd_q, quiet_q, gap_q, space_q;
  logic [2:0]  xset_q;
  logic [31:0] run_q;

  assign wr_ap = hready_in && hsel_in && htrans_in[1] && hwrite_in;

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      ctrl_q <= 1'b0;
      cmd_q  <= 1'b0;
    end else begin
      ctrl_q <= wr_ap && haddr_in[7:0] == OFS_CTRL;
      cmd_q  <= wr_ap && haddr_in[7:0] == OFS_CMD;
    end
  end

  // Shadow of the control word
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      quiet_q <= RST_QUIET;
      gap_q   <= RST_GAP_EN;
      xset_q  <= RST_XSET;
    end else if (ctrl_q) begin
      quiet_q <= hwdata_in[CTRL_QUIET_BIT];
      gap_q   <= hwdata_in[CTRL_GAP_BIT];
      if (hwdata_in[CTRL_XSET_LSB +: 3] <= XSET_MAX) begin
        xset_q <= hwdata_in[CTRL_XSET_LSB +: 3];
      end
    end
  end

  // Length of the latest space run
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      space_q <= 1'b0;
      run_q   <= '0;
    end else begin
      space_q <= rx_space_in;
      if (rx_space_in && !space_q) begin
        run_q <= 32'h1;
      end else if (rx_space_in) begin
        run_q <= run_q + 32'h1;
      end
    end
  end

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);

  sequence s_cmd_wr;
    cmd_q && !quiet_q && !tx_valid_out;
  endsequence
  sequence s_stall;
    tx_valid_out && !tx_ready_in;
  endsequence
  sequence s_ctrl_wr;
    ctrl_q && hwdata_in[CTRL_XSET_LSB +: 3] <= XSET_MAX;
  endsequence

  a_bus_okay: assert property (hreadyout_out && !hresp_out)
    else $error("bus answer not ready okay");
  a_cmd_answer: assert property (s_cmd_wr |-> ##[1:2] tx_valid_out)
    else $error("no result after command");
  a_tx_hold: assert property (s_stall |=> tx_valid_out && $stable(tx_char_out))
    else $error("result char dropped while stalled");
  a_quiet_mute: assert property (quiet_q && !tx_valid_out |=> !tx_valid_out)
    else $error("result sent while quiet");
  a_tone_pair: assert property (tone_timeout_en_out == wait_dial_tone_out)
    else $error("tone timeout differs from tone wait");
  a_full_decode: assert property (s_ctrl_wr |-> ##2 full_msgs_out == (xset_q != 3'h0))
    else $error("full message flag wrong");
  a_busy_decode: assert property (s_ctrl_wr |-> ##2 busy_detect_en_out == (xset_q >= 3'h3))
    else $error("busy detect flag wrong");
  a_tone_decode: assert property (s_ctrl_wr |-> ##2
    wait_dial_tone_out == (xset_q == 3'h2 || xset_q == 3'h4))
    else $error("dial tone flag wrong");
  a_hangup_once: assert property (hangup_out |=> !hangup_out)
    else $error("hangup longer than one cycle");
  a_hangup_cause: assert property (hangup_out |-> gap_q && run_q >= GAP_CYC)
    else $error("hangup without long enabled space");
endmodule : mrc_result_cmds_checker

bind mrc_result_cmds mrc_result_cmds_checker #(.GAP_CYC(GAP_CYC)) chk (.*);

// >>> mrc_host_model.sv
`timescale 1ns/1ps

module mrc_host_model (
  // Clock and reset
  input  wire logic        clk_sys_in,
  input  wire logic        rst_in,
  // Result characters
  input  wire logic [7:0]  tx_char_in,
  input  wire logic        tx_valid_in,
  output logic             tx_ready_out,
  // Pacing and capture
  input  wire logic        slow_in,
  output logic      [7:0]  rx_cnt_out,
  output logic      [31:0] rx_hist_out
);
  // Slow mode stalls every other cycle
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      tx_ready_out <= 1'b1;
      rx_cnt_out   <= 8'h00;
      rx_hist_out  <= 32'h0;
    end else begin
      tx_ready_out <= slow_in ? !tx_ready_out : 1'b1;
      if (tx_valid_in && tx_ready_out) begin
        rx_cnt_out  <= rx_cnt_out + 8'h01;
        rx_hist_out <= {rx_hist_out[23:0], tx_char_in};
      end
    end
  end
endmodule : mrc_host_model

// >>> mrc_result_cmds_tb.sv
`timescale 1ns/1ps

module mrc_result_cmds_tb
  import mrc_pkg::*;
;
  logic        clk = 1'b0, rst, hwrite, hready, hresp, slow;
  logic [31:0] haddr, hwdata, hrdata, rx_hist, q;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        conn, fast, no_tone;
  logic [3:0]  ev_exp [3] = '{RC_CONNECT, RC_CONFAST, RC_NOTONE};
  logic [7:0]  tx_char, rx_cnt, n;
  logic        tx_valid, tx_ready, online, space, busy_t, hangup;
  logic [3:0]  pol_now;
  logic [3:0]  pol [5] = '{4'h0, 4'h8, 4'hE, 4'h9, 4'hF};
  int          error_cnt = 0, n_checks = 0, cyc = 0, hang_n = 0;

  always #50 clk = ~clk;

  mrc_result_cmds #(.GAP_CYC(50)) mrc_result_cmds_inst (
    .clk_sys_in(clk), .rst_in(rst), .hsel_in(1'b1), .haddr_in(haddr),
    .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsize), .hwdata_in(hwdata),
    .hready_in(hready), .hrdata_out(hrdata), .hreadyout_out(hready),
    .hresp_out(hresp), .tx_char_out(tx_char), .tx_valid_out(tx_valid),
    .tx_ready_in(tx_ready), .online_in(online), .rx_space_in(space),
    .connect_in(conn), .fast_link_in(fast), .busy_tone_in(busy_t),
    .no_tone_in(no_tone), .full_msgs_out(pol_now[3]), .wait_dial_tone_out(pol_now[2]),
    .tone_timeout_en_out(pol_now[1]), .busy_detect_en_out(pol_now[0]),
    .hangup_out(hangup));

  mrc_host_model mrc_host_model_inst (
    .clk_sys_in(clk), .rst_in(rst), .tx_char_in(tx_char), .tx_valid_in(tx_valid),
    .tx_ready_out(tx_ready), .slow_in(slow), .rx_cnt_out(rx_cnt),
    .rx_hist_out(rx_hist));

  task automatic report_and_stop();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : report_and_stop

  always @(posedge clk) begin
    cyc++;
    if (hangup === 1'b1) hang_n++;
    if (cyc == 20000) begin
      error_cnt++;
      report_and_stop();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    haddr  <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    hsize  <= 3'h2;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    q = hrdata;
  endtask : xfer

  task automatic wait_idle();
    repeat (6) @(posedge clk);
    for (int i = 0; i < 100; i++) begin
      xfer(1'b0, OFS_STAT, 32'h0);
      if (q[STAT_BUSY_BIT] === 1'b0) break;
    end
  endtask : wait_idle

  task automatic cmd(input logic [1:0] op, input logic [7:0] i, input logic [8:0] v);
    xfer(1'b1, OFS_CMD, {7'h0, v, i, 6'h0, op});
    wait_idle();
  endtask : cmd

  // Refused command leaves an error and the ERROR word
  task automatic bad(input logic [1:0] op, input logic [7:0] i, input logic [8:0] v);
    cmd(op, i, v);
    check(32'({q[STAT_ERR_BIT], q[STAT_CODE_LSB +: 4]}), {27'h0, 1'b1, RC_ERROR});
    check(rx_hist, 32'h4F520D0A);
  endtask : bad

  initial begin
    rst <= 1'b1;
    haddr <= '0;
    htrans <= 2'h0;
    hwrite <= 1'b0;
    hwdata <= '0;
    slow <= 1'b0;
    online <= 1'b0;
    space <= 1'b0;
    busy_t <= 1'b0;
    conn <= 1'b0;
    fast <= 1'b0;
    no_tone <= 1'b0;
    hsize <= 3'h2;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    xfer(1'b0, OFS_CTRL, 32'h0);
    check(32'(q[5:0]), 32'h12);
    check(32'(pol_now), 32'hF);
    for (int i = 0; i < 6; i++) begin
      xfer(1'b1, OFS_CTRL, {26'h0, 1'b0, i[2:0], 2'h2});
      repeat (3) @(posedge clk);
      check(32'(pol_now), 32'(pol[i < 5 ? i : 4]));
    end
    for (int i = 1; i < 4; i += 2) begin
      xfer(1'b1, OFS_CTRL, {26'h0, 1'b0, i[2:0], 2'h2});
      busy_t <= 1'b1;
      repeat (4) @(posedge clk);
      busy_t <= 1'b0;
      wait_idle();
      check(32'(q[STAT_CODE_LSB +: 4]), 32'(i == 3 ? RC_BUSY : RC_NOCARR));
    end
    fast <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      xfer(1'b1, OFS_CTRL, {26'h0, 1'b0, i[2:0], 2'h2});
      conn <= (i < 2);
      no_tone <= (i == 2);
      repeat (4) @(posedge clk);
      conn <= 1'b0;
      no_tone <= 1'b0;
      wait_idle();
      check(32'(q[STAT_CODE_LSB +: 4]), 32'(ev_exp[i]));
    end
    xfer(1'b1, OFS_CTRL, 32'h12);
    slow <= 1'b1;
    cmd(OP_POKE, IDX_MAX, VAL_MAX);
    check(rx_hist, 32'h4F4B0D0A);
    check(32'(q[STAT_ERR_BIT]), 32'h0);
    cmd(OP_PEEK, IDX_MAX, 9'h0);
    check(32'(q[7:0]), 32'hFF);
    bad(OP_POKE, 8'h1C, 9'h001);
    bad(OP_POKE, IDX_MAX, 9'h100);
    bad(OP_PEEK, 8'h1C, 9'h000);
    cmd(OP_PEEK, IDX_MAX, 9'h0);
    check(32'(q[7:0]), 32'hFF);
    xfer(1'b1, OFS_CTRL, 32'h10);
    cmd(OP_PEEK, 8'h00, 9'h0);
    check(32'(rx_hist[15:0]), 32'h300D);
    xfer(1'b1, OFS_CTRL, 32'h13);
    n = rx_cnt;
    cmd(OP_POKE, 8'h00, 9'h005);
    cmd(OP_PEEK, 8'h00, 9'h0);
    check(32'(rx_cnt), 32'(n));
    check(32'(q[7:0]), 32'h05);
    xfer(1'b1, OFS_CTRL, 32'h12);
    online <= 1'b1;
    space <= 1'b1;
    repeat (80) @(posedge clk);
    space <= 1'b0;
    check(32'(hang_n), 32'h0);
    xfer(1'b1, OFS_CTRL, 32'h32);
    space <= 1'b1;
    repeat (80) @(posedge clk);
    space <= 1'b0;
    check(32'(hang_n), 32'h1);
    xfer(1'b0, OFS_STAT, 32'h0);
    check(32'(q[STAT_HUNG_BIT]), 32'h1);
    report_and_stop();
  end
endmodule : mrc_result_cmds_tb
